// ==== hdl/camera_io_counter_timer.v ====
// Digital I/O lines, user output word, event counters and us timers.
// Assumes all inputs are synchronous to core_clk; read data lags one cycle.
`timescale 1ns/1ns
`include "camera_io_map.vh"

module camera_io_counter_timer #(
	parameter NL = 8,  // Connector lines
	parameter NU = 8,  // User output bits
	parameter NC = 2,  // Counters
	parameter NT = 2,  // Timers
	parameter NX = 4,  // Internal acquisition signals
	parameter CW = 32, // Counter width
	parameter TW = 24  // Timer width in us
) (
	input  wire              core_clk,              // Core clock 20 MHz
	input  wire              rst,                   // Sync reset, high
	input  wire [NL-1:0]     pin_in,                // Line pad levels
	output reg  [NL-1:0]     pin_out,               // Line drive levels
	output reg  [NL-1:0]     pin_oe,                // Line drive enables
	input  wire [NX-1:0]     acq_signal,            // Internal sources
	input  wire [2:0]        pin_index_pick,        // Line selector
	input  wire              pin_cfg_wr,            // Line settings write
	input  wire              pin_direction_in,      // New direction
	input  wire              pin_polarity_flip_in,  // New inversion
	input  wire [`SRC_W-1:0] pin_drive_origin_in,   // New drive source
	output reg               pin_direction,         // Selected direction
	output reg               pin_polarity_flip,     // Selected inversion
	output reg  [`SRC_W-1:0] pin_drive_origin,      // Selected source
	output reg               pin_level,             // Selected line level
	output reg  [NL-1:0]     all_pin_levels,        // All line levels
	input  wire [2:0]        soft_out_bit_pick,     // User bit selector
	input  wire              soft_out_bit_wr,       // User bit write
	input  wire              soft_out_bit_value,    // User bit value
	input  wire              soft_out_word_wr,      // Whole word write
	input  wire [NU-1:0]     soft_out_word_in,      // Whole word value
	input  wire              soft_out_mask_wr,      // Mask write
	input  wire [NU-1:0]     soft_out_word_mask_in, // Mask value
	output reg  [NU-1:0]     soft_out_word,         // User output word
	output reg  [NU-1:0]     soft_out_word_mask,    // Write mask
	input  wire [0:0]        tally_index_pick,      // Counter selector
	input  wire              tally_cfg_wr,          // Counter setup write
	input  wire [`SRC_W-1:0] tally_increment_origin, // Event source
	input  wire [`ACT_W-1:0] tally_increment_edge,  // Event activation
	input  wire [`SRC_W-1:0] tally_clear_origin,    // Clear source
	input  wire [`ACT_W-1:0] tally_clear_edge,      // Clear activation
	input  wire [`SRC_W-1:0] tally_start_origin,    // Start source
	input  wire [`ACT_W-1:0] tally_start_edge,      // Start activation
	input  wire [CW-1:0]     tally_terminal_length, // Events to done
	input  wire              tally_soft_clear,      // Clear and start
	input  wire              tally_count_wr,        // Count write
	input  wire [CW-1:0]     tally_count_in,        // Count value
	output reg  [CW-1:0]     tally_count,           // Selected count
	output reg  [CW-1:0]     tally_captured_count,  // Count at clear
	output reg  [`TALLY_ST_W-1:0] tally_state,      // Selected state
	output reg  [NC-1:0]     tally_done_event,      // Done pulses
	input  wire [0:0]        pulse_unit_pick,       // Timer selector
	input  wire              pulse_cfg_wr,          // Timer setup write
	input  wire [TW-1:0]     pulse_length_us,       // Pulse length
	input  wire [TW-1:0]     pulse_lead_delay_us,   // Lead delay
	input  wire [`SRC_W-1:0] pulse_start_origin,    // Start source
	input  wire [`ACT_W-1:0] pulse_start_edge,      // Start activation
	input  wire              pulse_unit_soft_clear, // Clear and start
	input  wire              pulse_elapsed_wr,      // Elapsed write
	input  wire [TW-1:0]     pulse_elapsed_in,      // Elapsed value
	output reg  [TW-1:0]     pulse_elapsed_us,      // Selected elapsed
	output reg  [`PULSE_ST_W-1:0] pulse_unit_state, // Selected state
	output reg  [NT-1:0]     pulse_out              // Timer pulses
);
	localparam SRC_USED = 1 + NL + NU + NT + NC + NX;

	// Per-instance storage
	reg                    line_dir   [0:NL-1];
	reg                    line_flip  [0:NL-1];
	reg  [`SRC_W-1:0]      line_src   [0:NL-1];
	reg  [`SRC_W-1:0]      t_ev_src   [0:NC-1];
	reg  [`ACT_W-1:0]      t_ev_act   [0:NC-1];
	reg  [`SRC_W-1:0]      t_clr_src  [0:NC-1];
	reg  [`ACT_W-1:0]      t_clr_act  [0:NC-1];
	reg  [`SRC_W-1:0]      t_st_src   [0:NC-1];
	reg  [`ACT_W-1:0]      t_st_act   [0:NC-1];
	reg  [CW-1:0]          t_len      [0:NC-1];
	reg  [CW-1:0]          t_cnt      [0:NC-1];
	reg  [CW-1:0]          t_capt     [0:NC-1];
	reg  [`TALLY_ST_W-1:0] t_state    [0:NC-1];
	reg  [TW-1:0]          p_len      [0:NT-1];
	reg  [TW-1:0]          p_dly      [0:NT-1];
	reg  [`SRC_W-1:0]      p_st_src   [0:NT-1];
	reg  [`ACT_W-1:0]      p_st_act   [0:NT-1];
	reg  [TW-1:0]          p_el       [0:NT-1];
	reg  [`PULSE_ST_W-1:0] p_state    [0:NT-1];
	reg  [`US_DIV_W-1:0]   us_div;
	reg                    us_tick;
	wire [NL-1:0]          line_level;
	wire [SRC_USED-1:0]    src_used;
	wire [`SRC_BUS_W-1:0]  src_bus;
	wire [NC-1:0]          ev_hit;
	wire [NC-1:0]          clr_hit;
	wire [NC-1:0]          st_hit;
	wire [NT-1:0]          tm_hit;

	// Pick one source from the internal signal bus
	function pick_src;
		input [`SRC_BUS_W-1:0] bus;
		input [`SRC_W-1:0]     sel;
		begin
			pick_src = bus[sel];
		end
	endfunction

	// Line level as seen by the core: pad value, inverted if asked
	genvar g;
	generate
		for (g = 0; g < NL; g = g + 1) begin : gen_line
			assign line_level[g] = pin_in[g] ^ line_flip[g];
		end
	endgenerate

	// Source bus: 0 is constant low, then lines, user bits, timers,
	// counter ends, acquisition signals. Registered sources only feed
	// outputs through flops, so no combinational loop can form.
	assign src_used = {acq_signal, tally_done_event, pulse_out,
		soft_out_word, line_level, 1'b0};
	assign src_bus = {{(`SRC_BUS_W - SRC_USED){1'b0}}, src_used};

	// Activation qualifiers for counter event, clear and start, and for timer start
	generate
		for (g = 0; g < NC; g = g + 1) begin : gen_tq
			edge_qualifier u_ev (
				.core_clk (core_clk),
				.rst      (rst),
				.sig      (pick_src(src_bus, t_ev_src[g])),
				.mode     (t_ev_act[g]),
				.hit      (ev_hit[g])
			);
			edge_qualifier u_clr (
				.core_clk (core_clk),
				.rst      (rst),
				.sig      (pick_src(src_bus, t_clr_src[g])),
				.mode     (t_clr_act[g]),
				.hit      (clr_hit[g])
			);
			edge_qualifier u_st (
				.core_clk (core_clk),
				.rst      (rst),
				.sig      (pick_src(src_bus, t_st_src[g])),
				.mode     (t_st_act[g]),
				.hit      (st_hit[g])
			);
		end
		for (g = 0; g < NT; g = g + 1) begin : gen_pq
			edge_qualifier u_st (
				.core_clk (core_clk),
				.rst      (rst),
				.sig      (pick_src(src_bus, p_st_src[g])),
				.mode     (p_st_act[g]),
				.hit      (tm_hit[g])
			);
		end
	endgenerate

	// Microsecond enable; the first us after a start may be short
	// because the divider free-runs rather than restarting per timer.
	always @(posedge core_clk) begin
		if (rst) begin
			us_div  <= {`US_DIV_W{1'b0}};
			us_tick <= 1'b0;
		end else if (us_div == `US_CYC - 1) begin
			us_div  <= {`US_DIV_W{1'b0}};
			us_tick <= 1'b1;
		end else begin
			us_div  <= us_div + 1'b1;
			us_tick <= 1'b0;
		end
	end

	// Line settings, drive and user output word
	always @(posedge core_clk) begin : line_seq
		integer i;
		if (rst) begin
			for (i = 0; i < NL; i = i + 1) begin
				line_dir[i]  <= `DIR_IN;
				line_flip[i] <= 1'b0;
				line_src[i]  <= {`SRC_W{1'b0}};
			end
			pin_out            <= {NL{1'b0}};
			pin_oe             <= {NL{1'b0}};
			soft_out_word      <= {NU{1'b0}};
			soft_out_word_mask <= {NU{1'b1}};
		end else begin
			if (pin_cfg_wr) begin
				line_dir[pin_index_pick]  <= pin_direction_in;
				line_flip[pin_index_pick] <= pin_polarity_flip_in;
				line_src[pin_index_pick]  <= pin_drive_origin_in;
			end
			for (i = 0; i < NL; i = i + 1) begin
				pin_oe[i]  <= (line_dir[i] == `DIR_OUT);
				pin_out[i] <= pick_src(src_bus, line_src[i])
					^ line_flip[i];
			end
			if (soft_out_mask_wr)
				soft_out_word_mask <= soft_out_word_mask_in;
			// A bit write in the same cycle lands on top of a word write
			if (soft_out_word_wr)
				soft_out_word <= (soft_out_word & ~soft_out_word_mask)
					| (soft_out_word_in & soft_out_word_mask);
			if (soft_out_bit_wr)
				soft_out_word[soft_out_bit_pick] <= soft_out_bit_value;
		end
	end

	// Counters: soft clear, count write, clear source, start, event
	always @(posedge core_clk) begin : tally_seq
		integer i;
		if (rst) begin
			for (i = 0; i < NC; i = i + 1) begin
				t_ev_src[i]  <= {`SRC_W{1'b0}};
				t_ev_act[i]  <= `ACT_RISE;
				t_clr_src[i] <= {`SRC_W{1'b0}};
				t_clr_act[i] <= `ACT_RISE;
				t_st_src[i]  <= {`SRC_W{1'b0}};
				t_st_act[i]  <= `ACT_RISE;
				t_len[i]     <= {CW{1'b0}};
				t_cnt[i]     <= {CW{1'b0}};
				t_capt[i]    <= {CW{1'b0}};
				t_state[i]   <= `TALLY_IDLE;
			end
			tally_done_event <= {NC{1'b0}};
		end else begin
			for (i = 0; i < NC; i = i + 1) begin
				tally_done_event[i] <= 1'b0;
				if (tally_cfg_wr && tally_index_pick == i) begin
					t_ev_src[i]  <= tally_increment_origin;
					t_ev_act[i]  <= tally_increment_edge;
					t_clr_src[i] <= tally_clear_origin;
					t_clr_act[i] <= tally_clear_edge;
					t_st_src[i]  <= tally_start_origin;
					t_st_act[i]  <= tally_start_edge;
					t_len[i]     <= tally_terminal_length;
				end
				if (tally_soft_clear && tally_index_pick == i) begin
					t_capt[i]  <= t_cnt[i];
					t_cnt[i]   <= {CW{1'b0}};
					t_state[i] <= `TALLY_ACTIVE;
				end else if (tally_count_wr && tally_index_pick == i) begin
					t_cnt[i] <= tally_count_in;
				end else if (clr_hit[i]) begin
					t_capt[i] <= t_cnt[i];
					t_cnt[i]  <= {CW{1'b0}};
					// A cleared, completed counter resumes counting
					if (t_state[i] == `TALLY_DONE)
						t_state[i] <= `TALLY_ACTIVE;
				end else begin
					case (t_state[i])
						`TALLY_IDLE: begin
							if (st_hit[i])
								t_state[i] <= `TALLY_ACTIVE;
						end
						`TALLY_ACTIVE: begin
							if (ev_hit[i]) begin
								t_cnt[i] <= t_cnt[i] + 1'b1;
								if (t_cnt[i] + 1'b1 == t_len[i]) begin
									tally_done_event[i] <= 1'b1;
									t_state[i] <= `TALLY_DONE;
								end
							end
						end
						`TALLY_DONE: t_state[i] <= `TALLY_DONE;
						default:     t_state[i] <= `TALLY_IDLE;
					endcase
				end
			end
		end
	end

	// Timers: delay then pulse, both counted in microsecond ticks
	always @(posedge core_clk) begin : pulse_seq
		integer i;
		if (rst) begin
			for (i = 0; i < NT; i = i + 1) begin
				p_len[i]    <= {TW{1'b0}};
				p_dly[i]    <= {TW{1'b0}};
				p_st_src[i] <= {`SRC_W{1'b0}};
				p_st_act[i] <= `ACT_RISE;
				p_el[i]     <= {TW{1'b0}};
				p_state[i]  <= `PULSE_IDLE;
			end
		end else begin
			for (i = 0; i < NT; i = i + 1) begin
				if (pulse_cfg_wr && pulse_unit_pick == i) begin
					p_len[i]    <= pulse_length_us;
					p_dly[i]    <= pulse_lead_delay_us;
					p_st_src[i] <= pulse_start_origin;
					p_st_act[i] <= pulse_start_edge;
				end
				if (pulse_unit_soft_clear && pulse_unit_pick == i) begin
					p_el[i]    <= {TW{1'b0}};
					p_state[i] <= `PULSE_DELAY;
				end else if (pulse_elapsed_wr && pulse_unit_pick == i) begin
					p_el[i] <= pulse_elapsed_in;
				end else begin
					case (p_state[i])
						`PULSE_IDLE, `PULSE_DONE: begin
							if (tm_hit[i]) begin
								p_el[i]    <= {TW{1'b0}};
								p_state[i] <= `PULSE_DELAY;
							end
						end
						`PULSE_DELAY: begin
							if (p_el[i] >= p_dly[i]) begin
								p_el[i]    <= {TW{1'b0}};
								p_state[i] <= `PULSE_ACTIVE;
							end else if (us_tick)
								p_el[i] <= p_el[i] + 1'b1;
						end
						`PULSE_ACTIVE: begin
							if (p_el[i] >= p_len[i])
								p_state[i] <= `PULSE_DONE;
							else if (us_tick)
								p_el[i] <= p_el[i] + 1'b1;
						end
						default: p_state[i] <= `PULSE_IDLE;
					endcase
				end
			end
		end
	end

	// Pulse outputs and selected read-back, all registered
	always @(posedge core_clk) begin : readback_seq
		integer i;
		if (rst) begin
			pulse_out            <= {NT{1'b0}};
			pin_direction        <= `DIR_IN;
			pin_polarity_flip    <= 1'b0;
			pin_drive_origin     <= {`SRC_W{1'b0}};
			pin_level            <= 1'b0;
			all_pin_levels       <= {NL{1'b0}};
			tally_count          <= {CW{1'b0}};
			tally_captured_count <= {CW{1'b0}};
			tally_state          <= `TALLY_IDLE;
			pulse_elapsed_us     <= {TW{1'b0}};
			pulse_unit_state     <= `PULSE_IDLE;
		end else begin
			for (i = 0; i < NT; i = i + 1)
				pulse_out[i] <= (p_state[i] == `PULSE_ACTIVE)
					&& (p_el[i] < p_len[i]);
			pin_direction        <= line_dir[pin_index_pick];
			pin_polarity_flip    <= line_flip[pin_index_pick];
			pin_drive_origin     <= line_src[pin_index_pick];
			pin_level            <= line_level[pin_index_pick];
			all_pin_levels       <= line_level;
			tally_count          <= t_cnt[tally_index_pick];
			tally_captured_count <= t_capt[tally_index_pick];
			tally_state          <= t_state[tally_index_pick];
			pulse_elapsed_us     <= p_el[pulse_unit_pick];
			pulse_unit_state     <= p_state[pulse_unit_pick];
		end
	end
endmodule

// ==== common/camera_io_map.vh ====
// Constants for the camera digital I/O, counter and timer block.
// Assumes a 20 MHz core clock; times are derived from the clock period.
`ifndef CAMERA_IO_MAP_VH
`define CAMERA_IO_MAP_VH

// Clock period and microsecond tick
`define CLK_PERIOD_NS  50
`define US_NS          1000
`define US_CYC         ((`US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define US_DIV_W       5

// Activation modes of a source signal
`define ACT_W          2
`define ACT_RISE       2'h0
`define ACT_FALL       2'h1
`define ACT_ANY        2'h2
`define ACT_HIGH       2'h3

// Source select width; code 0 is a constant low source
`define SRC_W          5
`define SRC_BUS_W      32

// Line direction
`define DIR_IN         1'h0
`define DIR_OUT        1'h1

// Counter states
`define TALLY_ST_W     2
`define TALLY_IDLE     2'h0
`define TALLY_ACTIVE   2'h1
`define TALLY_DONE     2'h2

// Timer states
`define PULSE_ST_W     2
`define PULSE_IDLE     2'h0
`define PULSE_DELAY    2'h1
`define PULSE_ACTIVE   2'h2
`define PULSE_DONE     2'h3

`endif

// ==== hdl/edge_qualifier.v ====
// Activation qualifier: turns a source level into a hit, one cycle per edge or every cycle while high.
// Assumes the source is synchronous to core_clk.
`timescale 1ns/1ns
`include "camera_io_map.vh"

module edge_qualifier (
	input  wire                core_clk, // Core clock
	input  wire                rst,      // Synchronous reset, high
	input  wire                sig,      // Selected source level
	input  wire [`ACT_W-1:0]   mode,     // Activation mode
	output reg                 hit       // Qualified event, comb
);
	reg prev;

	// Remember last level; reset to low so a high source gives a rise
	always @(posedge core_clk) begin
		if (rst)
			prev <= 1'b0;
		else
			prev <= sig;
	end

	// Decode which condition counts as one event
	always @* begin
		case (mode)
			`ACT_RISE: hit = sig & ~prev;
			`ACT_FALL: hit = ~sig & prev;
			`ACT_ANY:  hit = sig ^ prev;
			`ACT_HIGH: hit = sig;
			default:   hit = 1'b0;
		endcase
	end
endmodule

// ==== bench/ext_equipment.sv ====
// Equipment wired to the connector lines of the I/O block.
// Assumes one pad per line; the block's driver wins when enabled.
`timescale 1ns/1ns
module ext_equipment (
	input  wire logic [7:0] pin_out,   // Block drive levels
	input  wire logic [7:0] pin_oe,    // Block drive enables
	input  wire logic [7:0] ext_drive, // Equipment levels
	output logic      [7:0] pin_in     // Resolved pad levels
);
	// Equipment drives only lines the block leaves as inputs
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule

// ==== bench/cio_checker_assertions.sv ====
// Port checker for the I/O, counter and timer block.
// Bound to the top module; read ports lag their selector by one cycle.
`timescale 1ns/1ns
`include "camera_io_map.vh"
module cio_checker #(
	parameter NL = 8,  // Connector lines
	parameter NU = 8,  // User output bits
	parameter NC = 2,  // Counters
	parameter CW = 32  // Counter width
) (
	input wire logic                   core_clk,             // Clock
	input wire logic                   rst,                  // Reset
	input wire logic [NL-1:0]          pin_oe,               // Enables
	input wire logic [NL-1:0]          all_pin_levels,       // Levels
	input wire logic [2:0]             pin_index_pick,       // Line pick
	input wire logic                   pin_cfg_wr,           // Line write
	input wire logic                   pin_direction_in,     // New dir
	input wire logic                   pin_polarity_flip_in, // New flip
	input wire logic                   pin_direction,        // Dir
	input wire logic                   pin_polarity_flip,    // Flip
	input wire logic                   pin_level,            // Level
	input wire logic [2:0]             soft_out_bit_pick,    // Bit pick
	input wire logic                   soft_out_bit_wr,      // Bit write
	input wire logic                   soft_out_bit_value,   // Bit value
	input wire logic                   soft_out_word_wr,     // Word write
	input wire logic [NU-1:0]          soft_out_word_in,     // Word in
	input wire logic                   soft_out_mask_wr,     // Mask write
	input wire logic [NU-1:0]          soft_out_word,        // Word
	input wire logic [NU-1:0]          soft_out_word_mask,   // Mask
	input wire logic [0:0]             tally_index_pick,     // Counter pick
	input wire logic                   tally_soft_clear,     // Soft clear
	input wire logic [CW-1:0]          tally_count,          // Count
	input wire logic [CW-1:0]          tally_captured_count, // Captured
	input wire logic [`TALLY_ST_W-1:0] tally_state,          // State
	input wire logic [NC-1:0]          tally_done_event      // Done pulses
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	logic was_rst;

	// Remembers reset so the first free cycle can be judged
	always @(posedge core_clk) begin
		was_rst <= rst;
	end

	// Setting write or soft clear followed by a steady selector
	sequence s_cfg_held;
		pin_cfg_wr ##1 (!pin_cfg_wr && $stable(pin_index_pick));
	endsequence
	sequence s_clr_held;
		tally_soft_clear ##1 (!tally_soft_clear && $stable(tally_index_pick));
	endsequence

	a_reset_vals: assert property (was_rst |-> soft_out_word_mask == 8'hff
		&& soft_out_word == 8'h00 && tally_state == `TALLY_IDLE)
		else $error("state after reset wrong");
	a_level_pick: assert property (pin_level ==
		all_pin_levels[$past(pin_index_pick)])
		else $error("line level differs from level word");
	a_oe_dir: assert property (pin_direction ==
		pin_oe[$past(pin_index_pick)])
		else $error("drive enable differs from direction");
	a_line_store: assert property (s_cfg_held |=>
		pin_direction == $past(pin_direction_in, 2) &&
		pin_polarity_flip == $past(pin_polarity_flip_in, 2))
		else $error("line settings not stored");
	a_bit_only: assert property (soft_out_bit_wr && !soft_out_word_wr |=>
		soft_out_word[$past(soft_out_bit_pick)] == $past(soft_out_bit_value)
		&& ((soft_out_word ^ $past(soft_out_word)) &
		~(8'h01 << $past(soft_out_bit_pick))) == 8'h00)
		else $error("bit write disturbed the word");
	a_word_mask: assert property (soft_out_word_wr && !soft_out_bit_wr &&
		!soft_out_mask_wr |=> soft_out_word == (($past(soft_out_word) &
		~$past(soft_out_word_mask)) | ($past(soft_out_word_in) &
		$past(soft_out_word_mask))))
		else $error("masked word write wrong");
	a_done_state: assert property (tally_done_event[0] &&
		tally_index_pick == 1'h0 |=> tally_state == `TALLY_DONE)
		else $error("done pulse without done state");
	a_clear_capture: assert property (s_clr_held |=>
		tally_captured_count == $past(tally_count))
		else $error("captured count wrong after clear");
endmodule

// ==== bench/tb_camera_io_counter_timer.sv ====
// Bench for the I/O, counter and timer block: lines, user word,
// counters 0 and 1 and timer 0. Assumes the equipment model and the checker.
`timescale 1ns/1ns
`include "camera_io_map.vh"
module tb_camera_io_counter_timer;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  pin_in, pin_out, pin_oe, all_pin_levels, ext_drive;
	logic [7:0]  soft_out_word_in, soft_out_word_mask_in;
	logic [7:0]  soft_out_word, soft_out_word_mask;
	logic [3:0]  acq_signal;
	logic [2:0]  pin_index_pick, soft_out_bit_pick;
	logic [4:0]  pin_drive_origin_in, pin_drive_origin, pulse_start_origin;
	logic [4:0]  tally_increment_origin, tally_clear_origin;
	logic [4:0]  tally_start_origin;
	logic        pin_cfg_wr, pin_direction_in, pin_polarity_flip_in;
	logic        pin_direction, pin_polarity_flip, pin_level;
	logic        soft_out_bit_wr, soft_out_bit_value;
	logic        soft_out_word_wr, soft_out_mask_wr;
	logic [0:0]  tally_index_pick, pulse_unit_pick;
	logic        tally_cfg_wr, tally_soft_clear, tally_count_wr;
	logic [1:0]  tally_increment_edge, tally_clear_edge, tally_start_edge;
	logic [1:0]  tally_state, tally_done_event, pulse_out;
	logic [1:0]  pulse_unit_state, pulse_start_edge;
	logic [31:0] tally_terminal_length, tally_count_in;
	logic [31:0] tally_count, tally_captured_count;
	logic        pulse_cfg_wr, pulse_unit_soft_clear, pulse_elapsed_wr;
	logic [23:0] pulse_length_us, pulse_lead_delay_us;
	logic [23:0] pulse_elapsed_in, pulse_elapsed_us;
	int          err_total, n_checks, n_done, cyc, w;

	camera_io_counter_timer u_dut (.*);
	ext_equipment u_ext (.*);

	// Clock and time-zero input values
	initial begin
		{ext_drive, soft_out_word_in, soft_out_word_mask_in, acq_signal,
			pin_index_pick, soft_out_bit_pick, pin_drive_origin_in,
			pulse_start_origin, tally_increment_origin, tally_clear_origin,
			tally_start_origin, pin_cfg_wr, pin_direction_in,
			pin_polarity_flip_in, soft_out_bit_wr, soft_out_bit_value,
			soft_out_word_wr, soft_out_mask_wr, tally_index_pick,
			pulse_unit_pick, tally_cfg_wr, tally_soft_clear, tally_count_wr,
			tally_increment_edge, tally_clear_edge, tally_start_edge,
			pulse_start_edge, tally_terminal_length, tally_count_in,
			pulse_cfg_wr, pulse_unit_soft_clear, pulse_elapsed_wr,
			pulse_length_us, pulse_lead_delay_us, pulse_elapsed_in} = '0;
		forever #25 core_clk = ~core_clk;
	end

	// Done pulses and cycle ceiling; a hang ends as a mismatch
	always @(posedge core_clk) begin
		n_done = n_done + int'(tally_done_event[0] === 1'b1);
		cyc = cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic line_cfg(input logic [2:0] i, input logic d, f,
		input logic [4:0] s);
		@(posedge core_clk);
		pin_index_pick <= i;
		pin_direction_in <= d;
		pin_polarity_flip_in <= f;
		pin_drive_origin_in <= s;
		pin_cfg_wr <= 1'b1;
		@(posedge core_clk);
		pin_cfg_wr <= 1'b0;
	endtask
	task automatic bit_wr(input logic [2:0] i, input logic v);
		@(posedge core_clk);
		soft_out_bit_pick <= i;
		soft_out_bit_value <= v;
		soft_out_bit_wr <= 1'b1;
		@(posedge core_clk);
		soft_out_bit_wr <= 1'b0;
	endtask
	// Mask then word, back to back so the new mask must already apply
	task automatic word_wr(input logic [7:0] m, v);
		@(posedge core_clk);
		soft_out_word_mask_in <= m;
		soft_out_mask_wr <= 1'b1;
		@(posedge core_clk);
		soft_out_mask_wr <= 1'b0;
		soft_out_word_in <= v;
		soft_out_word_wr <= 1'b1;
		@(posedge core_clk);
		soft_out_word_wr <= 1'b0;
	endtask
	task automatic pin_pulse(input int b);
		@(posedge core_clk);
		ext_drive[b] <= 1'b1;
		repeat (3) @(posedge core_clk);
		ext_drive[b] <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask

	// Line 3 outputs inverted user bit 0; line 5 reads inverted
	task automatic t_lines();
		settle(1);
		chk(soft_out_word_mask, 8'hff);
		line_cfg(3'h3, `DIR_OUT, 1'b1, 5'h09);
		bit_wr(3'h0, 1'b1);
		line_cfg(3'h5, `DIR_IN, 1'b1, 5'h00);
		ext_drive <= 8'h20;
		settle(3);
		chk(pin_oe, 8'h08);
		chk(pin_out[3], 1'b0);
		chk(all_pin_levels, 8'h08);
		chk(pin_level, 1'b0);
		@(posedge core_clk);
		pin_index_pick <= 3'h3;
		settle(2);
		chk(pin_level, 1'b1);
		chk(pin_direction, `DIR_OUT);
		chk(pin_drive_origin, 5'h09);
		bit_wr(3'h0, 1'b0);
		settle(2);
		chk(pin_out[3], 1'b1);
	endtask

	task automatic t_user();
		word_wr(8'h0f, 8'hff);
		settle(1);
		chk(soft_out_word, 8'h0f);
		word_wr(8'hf0, 8'h30);
		settle(1);
		chk(soft_out_word, 8'h3f);
		bit_wr(3'h7, 1'b1);
		settle(1);
		chk(soft_out_word, 8'hbf);
	endtask

	// First rise starts, three more count; line 1 falling clears
	task automatic t_counter();
		@(posedge core_clk);
		tally_increment_origin <= 5'h01;
		tally_increment_edge <= `ACT_RISE;
		tally_clear_origin <= 5'h02;
		tally_clear_edge <= `ACT_FALL;
		tally_start_origin <= 5'h01;
		tally_start_edge <= `ACT_RISE;
		tally_terminal_length <= 32'h3;
		tally_cfg_wr <= 1'b1;
		@(posedge core_clk);
		tally_cfg_wr <= 1'b0;
		pin_pulse(0);
		settle(1);
		chk(tally_state, `TALLY_ACTIVE);
		chk(tally_count, 32'h0);
		repeat (3) pin_pulse(0);
		settle(1);
		chk(n_done, 1);
		chk(tally_count, 32'h3);
		chk(tally_state, `TALLY_DONE);
		pin_pulse(1);
		settle(1);
		chk(tally_captured_count, 32'h3);
		chk(tally_count, 32'h0);
		@(posedge core_clk);
		tally_count_in <= 32'h7;
		tally_count_wr <= 1'b1;
		@(posedge core_clk);
		tally_count_wr <= 1'b0;
		tally_soft_clear <= 1'b1;
		@(posedge core_clk);
		tally_soft_clear <= 1'b0;
		settle(2);
		chk(tally_captured_count, 32'h7);
		chk(tally_count, 32'h0);
		chk(tally_state, `TALLY_ACTIVE);
		@(posedge core_clk);
		tally_index_pick <= 1'h1;
		settle(2);
		chk(tally_state, `TALLY_IDLE);
		// Counter 1: started by a high acquisition level, counts both edges
		@(posedge core_clk);
		tally_increment_edge <= `ACT_ANY;
		tally_start_origin <= 5'h15;
		tally_start_edge <= `ACT_HIGH;
		acq_signal <= 4'h1;
		tally_cfg_wr <= 1'b1;
		@(posedge core_clk);
		tally_cfg_wr <= 1'b0;
		pin_pulse(0);
		settle(1);
		chk(tally_count, 32'h2);
		chk(tally_state, `TALLY_ACTIVE);
	endtask

	// Timer 0: 2 us lead, 3 us pulse, started by line 0 rising
	task automatic t_timer();
		@(posedge core_clk);
		pulse_length_us <= 24'h3;
		pulse_lead_delay_us <= 24'h2;
		pulse_start_origin <= 5'h01;
		pulse_start_edge <= `ACT_RISE;
		pulse_cfg_wr <= 1'b1;
		@(posedge core_clk);
		pulse_cfg_wr <= 1'b0;
		ext_drive[0] <= 1'b1;
		settle(5);
		chk(pulse_unit_state, `PULSE_DELAY);
		w = 5;
		while (pulse_out[0] !== 1'b1 && w < 200) begin
			settle(1);
			w++;
		end
		chk(w >= 20 && w <= 45, 1'b1);
		w = 0;
		while (pulse_out[0] === 1'b1 && w < 200) begin
			settle(1);
			w++;
		end
		chk(w >= 40 && w <= 62, 1'b1);
		settle(2);
		chk(pulse_unit_state, `PULSE_DONE);
		chk(pulse_out[1], 1'b0);
		@(posedge core_clk);
		ext_drive[0] <= 1'b0;
		pulse_elapsed_in <= 24'h5;
		pulse_elapsed_wr <= 1'b1;
		@(posedge core_clk);
		pulse_elapsed_wr <= 1'b0;
		settle(2);
		chk(pulse_elapsed_us, 24'h5);
		@(posedge core_clk);
		pulse_unit_soft_clear <= 1'b1;
		@(posedge core_clk);
		pulse_unit_soft_clear <= 1'b0;
		settle(2);
		chk(pulse_unit_state, `PULSE_DELAY);
		chk(pulse_elapsed_us <= 24'h1, 1'b1);
	endtask

	task automatic stop_test();
		$display("Checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Reset for 12 cycles, then each scenario in turn
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		t_lines();
		t_user();
		t_counter();
		t_timer();
		stop_test();
	end
endmodule

bind camera_io_counter_timer cio_checker #(.NL(NL), .NU(NU), .NC(NC),
	.CW(CW)) u_chk (.*);
